// ===== hdl/gdls_status_bank.sv
`timescale 1ns/1ps
module gdls_status_bank (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // loop results, index 0 is pair a
  input wire gdls_pkg::gdls_pair_t loop_in [gdls_pkg::GDLS_PAIRS],
  input wire logic thermal_fault,
  input wire logic watchdog_fault,
  output logic thermal_watchdog_loop_summary,
  // axi4-lite write address
  input wire logic [gdls_pkg::GDLS_ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  // axi4-lite write data
  input wire logic [gdls_pkg::GDLS_DATA_W-1:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  // axi4-lite write response
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // axi4-lite read address
  input wire logic [gdls_pkg::GDLS_ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  // axi4-lite read data
  output logic [gdls_pkg::GDLS_DATA_W-1:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);
  localparam int NP = gdls_pkg::GDLS_PAIRS;
  localparam int RW = gdls_pkg::GDLS_REG_W;
  localparam int AW = gdls_pkg::GDLS_ADDR_W;
  localparam logic [AW-1:0] A_CUR_POL = {gdls_pkg::GDLS_IDX_CUR_POL, gdls_pkg::GDLS_IDX_SHIFT};
  localparam logic [AW-1:0] A_CHG_LIM = {gdls_pkg::GDLS_IDX_CHG_LIM, gdls_pkg::GDLS_IDX_SHIFT};
  localparam logic [AW-1:0] A_SLEW_OVF = {gdls_pkg::GDLS_IDX_SLEW_OVF, gdls_pkg::GDLS_IDX_SHIFT};
  localparam logic [AW-1:0] A_LOOP_CTRL = {gdls_pkg::GDLS_IDX_LOOP_CTRL, gdls_pkg::GDLS_IDX_SHIFT};

  gdls_pkg::gdls_pair_t flags [NP];
  logic [RW-1:0] ctrl_ff;
  logic [NP-1:0] dir, unk, pch, pdch, fslew, rslew, mode, level;
  logic [RW-1:0] stat_pol, stat_chg, stat_slew;

  // per pair flag holders, pair a on the top bit of each half
  for (genvar i = 0; i < NP; i++) begin : g_pair
    gdls_pair_status u_pair (
      .clk(clk),
      .rst_n(rst_n),
      .loop_in(loop_in[i]),
      .polarity_mode(mode[NP-1-i]),
      .half_bridge_level_control(level[NP-1-i]),
      .flags(flags[i])
    );
    assign dir[NP-1-i] = flags[i].dir;
    assign unk[NP-1-i] = flags[i].dir_unknown;
    assign pch[NP-1-i] = flags[i].precharge_limit;
    assign pdch[NP-1-i] = flags[i].predischarge_limit;
    assign fslew[NP-1-i] = flags[i].fall_slew_overflow;
    assign rslew[NP-1-i] = flags[i].rise_slew_overflow;
  end

  assign mode = ctrl_ff[gdls_pkg::GDLS_CTRL_MODE_LSB +: NP];
  assign level = ctrl_ff[gdls_pkg::GDLS_CTRL_LEVEL_LSB +: NP];
  assign stat_pol = {dir, unk};
  assign stat_chg = {pch, pdch};
  assign stat_slew = {fslew, rslew};

  // summary folds in every loop warning
  logic any_warn;
  assign any_warn = |{unk, pch, pdch, fslew, rslew} | thermal_fault | watchdog_fault;

  // write channel; address and data may arrive in either order
  logic aw_held_ff, w_held_ff, awready_ff, wready_ff, bvalid_ff;
  logic [AW-1:0] awaddr_ff;
  logic [gdls_pkg::GDLS_DATA_W-1:0] wdata_ff;
  logic wstrb0_ff;
  logic [1:0] bresp_ff;
  logic aw_fire, w_fire, have_aw, have_w, wr_do;
  logic nxt_aw_held, nxt_w_held, nxt_bvalid;
  logic [AW-1:0] wr_addr;
  logic [RW-1:0] wr_byte;
  logic wr_lane0, wr_ctrl, wr_status, wr_hit;

  assign aw_fire = s_awvalid && awready_ff;
  assign w_fire = s_wvalid && wready_ff;
  assign have_aw = aw_held_ff || aw_fire;
  assign have_w = w_held_ff || w_fire;
  assign wr_do = have_aw && have_w;
  assign nxt_aw_held = have_aw && !wr_do;
  assign nxt_w_held = have_w && !wr_do;
  assign nxt_bvalid = wr_do || (bvalid_ff && !s_bready);
  assign wr_addr = aw_fire ? s_awaddr : awaddr_ff;
  assign wr_byte = w_fire ? s_wdata[RW-1:0] : wdata_ff[RW-1:0];
  assign wr_lane0 = w_fire ? s_wstrb[0] : wstrb0_ff;
  assign wr_ctrl = wr_addr == A_LOOP_CTRL;
  assign wr_status = (wr_addr == A_CUR_POL) || (wr_addr == A_CHG_LIM) || (wr_addr == A_SLEW_OVF);
  // status writes answer okay but store nothing
  assign wr_hit = wr_ctrl || wr_status;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= gdls_pkg::GDLS_RESP_OKAY;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb0_ff <= 1'b0;
    end else begin
      aw_held_ff <= nxt_aw_held;
      w_held_ff <= nxt_w_held;
      awready_ff <= !nxt_aw_held && !nxt_bvalid;
      wready_ff <= !nxt_w_held && !nxt_bvalid;
      bvalid_ff <= nxt_bvalid;
      if (aw_fire) awaddr_ff <= s_awaddr;
      if (w_fire) wdata_ff <= s_wdata;
      if (w_fire) wstrb0_ff <= s_wstrb[0];
      if (wr_do) bresp_ff <= wr_hit ? gdls_pkg::GDLS_RESP_OKAY : gdls_pkg::GDLS_RESP_DECERR;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= gdls_pkg::GDLS_RST_CTRL;
    end else if (wr_do && wr_ctrl && wr_lane0) begin
      ctrl_ff <= wr_byte;
    end
  end

  // read channel; one read in flight, reads never disturb flags
  logic arready_ff, rvalid_ff, ar_fire, nxt_rvalid, rd_hit;
  logic [RW-1:0] rd_byte;
  logic [gdls_pkg::GDLS_DATA_W-1:0] rdata_ff;
  logic [1:0] rresp_ff;

  assign ar_fire = s_arvalid && arready_ff;
  assign nxt_rvalid = ar_fire || (rvalid_ff && !s_rready);
  assign rd_hit = (s_araddr == A_CUR_POL) || (s_araddr == A_CHG_LIM) ||
                  (s_araddr == A_SLEW_OVF) || (s_araddr == A_LOOP_CTRL);
  assign rd_byte = (s_araddr == A_CUR_POL) ? stat_pol :
                   (s_araddr == A_CHG_LIM) ? stat_chg :
                   (s_araddr == A_SLEW_OVF) ? stat_slew :
                   (s_araddr == A_LOOP_CTRL) ? ctrl_ff : gdls_pkg::GDLS_RST_STATUS;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= gdls_pkg::GDLS_RESP_OKAY;
      thermal_watchdog_loop_summary <= 1'b0;
    end else begin
      arready_ff <= !nxt_rvalid;
      rvalid_ff <= nxt_rvalid;
      if (ar_fire) rdata_ff <= gdls_pkg::GDLS_DATA_W'(rd_byte);
      if (ar_fire) rresp_ff <= rd_hit ? gdls_pkg::GDLS_RESP_OKAY : gdls_pkg::GDLS_RESP_DECERR;
      thermal_watchdog_loop_summary <= any_warn;
    end
  end

  assign s_awready = awready_ff;
  assign s_wready = wready_ff;
  assign s_bvalid = bvalid_ff;
  assign s_bresp = bresp_ff;
  assign s_arready = arready_ff;
  assign s_rvalid = rvalid_ff;
  assign s_rdata = rdata_ff;
  assign s_rresp = rresp_ff;

  // checks
  property p_dir_auto;
    @(posedge clk) disable iff (!rst_n)
    !mode[NP-1] |=> dir[NP-1] == $past(loop_in[0].dir);
  endproperty
  a_dir_auto: assert property (p_dir_auto) else $error("auto direction not tracked");

  property p_dir_manual;
    @(posedge clk) disable iff (!rst_n)
    mode[0] ##1 mode[0] |-> dir[0] == $past(level[0]);
  endproperty
  a_dir_manual: assert property (p_dir_manual) else $error("manual direction wrong");

  property p_unknown;
    @(posedge clk) disable iff (!rst_n)
    1'b1 |=> unk[NP-1] == $past(!mode[NP-1] && loop_in[0].dir_unknown);
  endproperty
  a_unknown: assert property (p_unknown) else $error("unknown warning wrong");

  property p_precharge;
    @(posedge clk) disable iff (!rst_n)
    loop_in[1].precharge_limit |=> stat_chg[RW-2];
  endproperty
  a_precharge: assert property (p_precharge) else $error("precharge flag missing");

  property p_predischarge;
    @(posedge clk) disable iff (!rst_n)
    $rose(loop_in[3].predischarge_limit) |=> stat_chg[0] &&
      stat_chg[RW-NP] == $past(loop_in[3].precharge_limit);
  endproperty
  a_predischarge: assert property (p_predischarge) else $error("predischarge flag wrong");

  property p_fall_slew;
    @(posedge clk) disable iff (!rst_n)
    1'b1 |=> stat_slew[RW-1] == $past(loop_in[0].fall_slew_overflow);
  endproperty
  a_fall_slew: assert property (p_fall_slew) else $error("fall slew flag wrong");

  property p_rise_slew;
    @(posedge clk) disable iff (!rst_n)
    1'b1 |=> stat_slew[NP-1] == $past(loop_in[0].rise_slew_overflow);
  endproperty
  a_rise_slew: assert property (p_rise_slew) else $error("rise slew flag wrong");

  property p_summary;
    @(posedge clk) disable iff (!rst_n)
    $rose(loop_in[2].fall_slew_overflow) |-> ##2 thermal_watchdog_loop_summary;
  endproperty
  a_summary: assert property (p_summary) else $error("summary misses slew warning");

  property p_ro_write;
    @(posedge clk) disable iff (!rst_n)
    wr_do && wr_status |=> ctrl_ff == $past(ctrl_ff) && s_bvalid && s_bresp == gdls_pkg::GDLS_RESP_OKAY;
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("status write not ignored");

  property p_read_pol;
    @(posedge clk) disable iff (!rst_n)
    ar_fire && s_araddr == A_CUR_POL |=> s_rvalid && s_rdata[RW-1:0] == $past(stat_pol);
  endproperty
  a_read_pol: assert property (p_read_pol) else $error("status read wrong");

  c_read_stat: cover property (@(posedge clk) disable iff (!rst_n) ar_fire && s_araddr == A_SLEW_OVF);
  c_write_ctrl: cover property (@(posedge clk) disable iff (!rst_n) wr_do && wr_ctrl);
  c_bad_addr: cover property (@(posedge clk) disable iff (!rst_n) wr_do && !wr_hit);
  c_summary: cover property (@(posedge clk) disable iff (!rst_n) thermal_watchdog_loop_summary);
endmodule : gdls_status_bank

// ===== pkg/gdls_pkg.sv
package gdls_pkg;

  localparam int GDLS_PAIRS = 4;
  localparam int GDLS_REG_W = 8;
  localparam int GDLS_DATA_W = 32;
  localparam int GDLS_ADDR_W = 10;

  // register indices; byte address is four times the index
  localparam logic [7:0] GDLS_IDX_CUR_POL = 8'h3C;
  localparam logic [7:0] GDLS_IDX_CHG_LIM = 8'h3D;
  localparam logic [7:0] GDLS_IDX_SLEW_OVF = 8'h3E;
  localparam logic [7:0] GDLS_IDX_LOOP_CTRL = 8'h40;
  localparam logic [1:0] GDLS_IDX_SHIFT = 2'h0;

  localparam logic [GDLS_REG_W-1:0] GDLS_RST_STATUS = 8'h00;
  localparam logic [GDLS_REG_W-1:0] GDLS_RST_CTRL = 8'h00;

  // loop control fields
  localparam int GDLS_CTRL_MODE_LSB = 0;
  localparam int GDLS_CTRL_LEVEL_LSB = 4;

  localparam logic [1:0] GDLS_RESP_OKAY = 2'h0;
  localparam logic [1:0] GDLS_RESP_DECERR = 2'h3;

  typedef struct packed {
    logic dir;
    logic dir_unknown;
    logic precharge_limit;
    logic predischarge_limit;
    logic fall_slew_overflow;
    logic rise_slew_overflow;
  } gdls_pair_t;

endpackage : gdls_pkg

// ===== hdl/gdls_pair_status.sv
`timescale 1ns/1ps
module gdls_pair_status (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // loop results and control
  input wire gdls_pkg::gdls_pair_t loop_in,
  input wire logic polarity_mode,
  input wire logic half_bridge_level_control,
  // held flags
  output gdls_pkg::gdls_pair_t flags
);
  gdls_pkg::gdls_pair_t nxt_flags;
  gdls_pkg::gdls_pair_t flags_ff;

  // manual mode: direction is commanded, so never unknown
  assign nxt_flags.dir = polarity_mode ? half_bridge_level_control : loop_in.dir;
  assign nxt_flags.dir_unknown = !polarity_mode && loop_in.dir_unknown;
  assign nxt_flags.precharge_limit = loop_in.precharge_limit;
  assign nxt_flags.predischarge_limit = loop_in.predischarge_limit;
  assign nxt_flags.fall_slew_overflow = loop_in.fall_slew_overflow;
  assign nxt_flags.rise_slew_overflow = loop_in.rise_slew_overflow;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_ff <= '0;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  assign flags = flags_ff;
endmodule : gdls_pair_status

// ===== dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk, rst_n, thermal_fault, watchdog_fault, summary;
  gdls_pkg::gdls_pair_t loop_in [gdls_pkg::GDLS_PAIRS];
  logic [9:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, rd;
  logic [3:0] s_wstrb, strb;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready;
  logic [1:0] s_bresp, s_rresp, resp;
  logic [7:0] ctrl, nv;
  int mismatches, n_compared;

  gdls_status_bank i_gdls_status_bank (.clk(clk), .rst_n(rst_n), .loop_in(loop_in),
    .thermal_fault(thermal_fault), .watchdog_fault(watchdog_fault),
    .thermal_watchdog_loop_summary(summary), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
    .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: data %h expected %h", $time, got, exp);
    end
  endtask : chk_data

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: response %h expected %h", $time, got, exp);
    end
  endtask : chk_resp

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run

  // each channel released on its own handshake edge
  task automatic axi_wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s);
    bit done;
    done = 0;
    @(posedge clk);
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= s;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
      if (s_bvalid && s_bready) begin
        resp = s_bresp;
        s_bready <= 1'b0;
        done = 1;
      end
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [9:0] a);
    bit done;
    done = 0;
    @(posedge clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
      if (s_rvalid && s_rready) begin
        rd = s_rdata;
        resp = s_rresp;
        s_rready <= 1'b0;
        done = 1;
      end
    end
  endtask : axi_rd

  // bit 7-i / 3-i belong to pair i; manual mode overrides direction
  function automatic logic [7:0] exp_reg(input int k);
    logic [7:0] b;
    b = 8'h00;
    for (int i = 0; i < 4; i++) begin
      case (k)
        0: begin
          b[7-i] = ctrl[3-i] ? ctrl[7-i] : loop_in[i].dir;
          b[3-i] = !ctrl[3-i] && loop_in[i].dir_unknown;
        end
        1: begin
          b[7-i] = loop_in[i].precharge_limit;
          b[3-i] = loop_in[i].predischarge_limit;
        end
        default: begin
          b[7-i] = loop_in[i].fall_slew_overflow;
          b[3-i] = loop_in[i].rise_slew_overflow;
        end
      endcase
    end
    return b;
  endfunction : exp_reg

  function automatic logic exp_sum();
    logic [7:0] a;
    a = exp_reg(0);
    return (|a[3:0]) | (|exp_reg(1)) | (|exp_reg(2)) | thermal_fault | watchdog_fault;
  endfunction : exp_sum

  // inputs held still so flags and summary have settled
  task automatic check_all;
    repeat (3) @(posedge clk);
    chk_data({31'h0, summary}, {31'h0, exp_sum()});
    for (int k = 0; k < 3; k++) begin
      axi_rd(10'h0F0 + 10'(4 * k));
      chk_resp(resp, gdls_pkg::GDLS_RESP_OKAY);
      chk_data(rd, {24'h0, exp_reg(k)});
    end
  endtask : check_all

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    complete_run();
  end

  initial begin
    void'($urandom(32'hC398));
    {rst_n, thermal_fault, watchdog_fault, s_awvalid, s_wvalid, s_bready} = '0;
    {s_arvalid, s_rready, s_awaddr, s_araddr, s_wdata, s_wstrb, ctrl} = '0;
    for (int i = 0; i < 4; i++) loop_in[i] = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    check_all();
    for (int n = 0; n < 40; n++) begin
      nv = 8'($urandom);
      strb = (n % 5 == 0) ? 4'hE : 4'hF;
      // upper data bits random, they must be ignored
      axi_wr(10'h100, {24'($urandom), nv}, strb);
      chk_resp(resp, gdls_pkg::GDLS_RESP_OKAY);
      if (strb[0]) ctrl = nv;
      @(posedge clk);
      for (int i = 0; i < 4; i++)
        loop_in[i] <= (n % 4 == 0) ? '0 : gdls_pkg::gdls_pair_t'($urandom & $urandom);
      thermal_fault <= ($urandom % 8 == 0);
      watchdog_fault <= ($urandom % 8 == 0);
      check_all();
      axi_rd(10'h100);
      chk_data(rd, {24'h0, ctrl});
      if (n % 3 == 0) begin
        axi_wr(10'h0F0 + 10'(4 * (n % 9 / 3)), 32'hFFFF_FFFF, 4'hF);
        chk_resp(resp, gdls_pkg::GDLS_RESP_OKAY);
        check_all();
      end
      if (n % 7 == 0) begin
        axi_rd(10'h0FC);
        chk_resp(resp, gdls_pkg::GDLS_RESP_DECERR);
        chk_data(rd, 32'h0000_0000);
        // well outside the status group, so no reserved offset is touched
        axi_wr(10'h200, 32'h0000_00FF, 4'hF);
        chk_resp(resp, gdls_pkg::GDLS_RESP_DECERR);
      end
    end
    complete_run();
  end
endmodule : tb_top
